/* verilog/fvi_defs.vh */
// Constants of the four vector interrupt unit
`ifndef FVI_DEFS_VH
`define FVI_DEFS_VH
`define FVI_ADDR_W            8
`define FVI_ADDR_CPU_STATUS   8'h00
`define FVI_ADDR_INT_STATUS   8'h01
`define FVI_ADDR_TMR_STATUS   8'h02
`define FVI_ADDR_PERI_REQ     8'h03
`define FVI_ADDR_PERI_EN      8'h04
`define FVI_ADDR_PEND         8'h05
`define FVI_BIT_GID           4
`define FVI_BIT_EXT_EN        0
`define FVI_BIT_TMR_EN        1
`define FVI_BIT_TCK_EN        2
`define FVI_BIT_PERI_EN       3
`define FVI_BIT_EXT_FLAG      4
`define FVI_BIT_TMR_FLAG      5
`define FVI_BIT_TCK_FLAG      6
`define FVI_BIT_PERI_FLAG     7
`define FVI_BIT_EXT_EDGE      7
`define FVI_BIT_TCK_EDGE      6
`define FVI_VEC_EXT           16'h0008
`define FVI_VEC_TMR           16'h0010
`define FVI_VEC_TCK           16'h0018
`define FVI_VEC_PERI          16'h0020
`define FVI_RST_CPU_STATUS    8'h10
`define FVI_RST_INT_STATUS    8'h00
`define FVI_RST_TMR_STATUS    8'h00
`endif

/* verilog/fvi_unit.v */
// Four vector interrupt unit: flags, enables, priority and vector redirect
//
// Operation
// - Global disable set blocks every interrupt
// - Reset sets the global disable bit
// - Peripheral needs own and group enable
// - Return instruction clears disable, pops PC
// - Taking interrupt sets disable, pushes, vectors
// - Vectors: pin 0008h, timer 0010h, clock 0018h
// - Peripherals share vector 0020h, software polls
// - Priority: pin, timer, clock pin, peripheral
// - Flags set regardless of any enable
// - Pin edge polarity chosen by edge-select bit
// - Pin edge sets flag bit4, enable bit0
// - External pin edge wakes from sleep
// - Clock pin polarity chosen by bit6
// - Clock pin edge sets bit6, enable bit2
// - Clock pin edge wakes from sleep
// - Peripheral flag is read-only OR of ANDs
// - Enabled peripheral requests wake from sleep
// - Only the return PC is pushed
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`include "fvi_defs.vh"
module fvi_unit #(
	parameter NPERI = 8
) (
	input  wire                   i_clk_sys,
	input  wire                   i_rst_b,
	input  wire [`FVI_ADDR_W-1:0] i_addr,
	input  wire [7:0]             i_wdata,
	input  wire                   i_wr,
	input  wire                   i_rd,
	output reg  [7:0]             o_rdata,
	input  wire                   i_ext_interrupt_pin,
	input  wire                   i_timer_clock_interrupt_pin,
	input  wire                   i_timer_overflow,
	input  wire [NPERI-1:0]       i_peri_event,
	input  wire                   i_core_accept,
	input  wire                   i_return_from_interrupt_instr,
	input  wire [15:0]            i_return_pc,
	input  wire [15:0]            i_stack_top,
	output wire                   o_int_request,
	output reg                    o_pc_load,
	output reg  [15:0]            o_pc_value,
	output reg                    o_stack_push,
	output reg  [15:0]            o_stack_data,
	output reg                    o_stack_pop,
	output wire                   o_wake,
	output wire                   o_global_int_disable
);
	reg        rst_meta_r;
	reg        rst_sync_r;
	wire       rst_n;
	reg  [7:0] cpu_status_reg_r;
	reg  [7:0] int_status_ctrl_reg_r;
	reg  [7:0] timer_status_ctrl_reg_r;
	reg  [NPERI-1:0] peripheral_request_regs_r;
	reg  [NPERI-1:0] peripheral_enable_regs_r;
	reg  [1:0] pin_d_r;
	wire [1:0] pin_now;
	wire [1:0] pin_rise_sel;
	wire [1:0] pin_edge;
	reg  [7:0] rdata_nxt;
	wire       global_int_disable;
	wire       ext_pin_edge;
	wire       tck_pin_edge;
	wire       peripheral_summary_flag;
	wire [3:0] pend;
	wire       take;
	wire [NPERI-1:0] peri_hit;
	wire       wr_cpu_status;
	wire       wr_int_status;
	wire       wr_tmr_status;
	wire       wr_peri_req;
	wire       wr_peri_en;
	reg  [3:0] grant;
	reg  [15:0] vector_sel;
	reg  [7:0] cpu_status_nxt;
	reg  [7:0] int_status_nxt;
	reg  [NPERI-1:0] peri_req_nxt;
	reg  [2:0] seq_state_r;
	reg  [2:0] seq_state_nxt;

	localparam [2:0] SEQ_IDLE   = 3'b001;
	localparam [2:0] SEQ_ENTRY  = 3'b010;
	localparam [2:0] SEQ_RETURN = 3'b100;

	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end
	assign rst_n = rst_sync_r;

	// Register write decode, one strobe per register
	assign wr_cpu_status = i_wr & (i_addr == `FVI_ADDR_CPU_STATUS);
	assign wr_int_status = i_wr & (i_addr == `FVI_ADDR_INT_STATUS);
	assign wr_tmr_status = i_wr & (i_addr == `FVI_ADDR_TMR_STATUS);
	assign wr_peri_req   = i_wr & (i_addr == `FVI_ADDR_PERI_REQ);
	assign wr_peri_en    = i_wr & (i_addr == `FVI_ADDR_PERI_EN);

	assign global_int_disable   = cpu_status_reg_r[`FVI_BIT_GID];
	assign o_global_int_disable = global_int_disable;

	// Edge select: set means rising, clear means falling
	assign pin_now      = {i_timer_clock_interrupt_pin, i_ext_interrupt_pin};
	assign pin_rise_sel = {timer_status_ctrl_reg_r[`FVI_BIT_TCK_EDGE],
		timer_status_ctrl_reg_r[`FVI_BIT_EXT_EDGE]};

	genvar p;
	generate
		for (p = 0; p < 2; p = p + 1) begin : g_pin
			assign pin_edge[p] = pin_rise_sel[p] ?
				(pin_now[p] & ~pin_d_r[p]) :
				(~pin_now[p] & pin_d_r[p]);
		end
	endgenerate
	assign ext_pin_edge = pin_edge[0];
	assign tck_pin_edge = pin_edge[1];

	genvar g;
	generate
		for (g = 0; g < NPERI; g = g + 1) begin : g_peri
			assign peri_hit[g] = peripheral_request_regs_r[g] & peripheral_enable_regs_r[g];
		end
	endgenerate
	assign peripheral_summary_flag = |peri_hit;

	assign pend[0] = int_status_ctrl_reg_r[`FVI_BIT_EXT_FLAG] &
		int_status_ctrl_reg_r[`FVI_BIT_EXT_EN];
	assign pend[1] = int_status_ctrl_reg_r[`FVI_BIT_TMR_FLAG] &
		int_status_ctrl_reg_r[`FVI_BIT_TMR_EN];
	assign pend[2] = int_status_ctrl_reg_r[`FVI_BIT_TCK_FLAG] &
		int_status_ctrl_reg_r[`FVI_BIT_TCK_EN];
	assign pend[3] = peripheral_summary_flag &
		int_status_ctrl_reg_r[`FVI_BIT_PERI_EN];

	assign o_int_request = (|pend) & ~global_int_disable;
	assign take          = o_int_request & i_core_accept;
	// Wake ignores the global disable, as a sleeping core still resumes
	assign o_wake        = pend[0] | pend[2] | pend[3];

	// Last sampled pin levels for the edge detectors
	always @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_d_r <= 2'b00;
		end else begin
			pin_d_r <= pin_now;
		end
	end

	// Global disable: reset sets, entry sets, return clears, write otherwise
	always @* begin
		cpu_status_nxt = cpu_status_reg_r;
		if (take) begin
			cpu_status_nxt[`FVI_BIT_GID] = 1'b1;
		end else if (i_return_from_interrupt_instr) begin
			cpu_status_nxt[`FVI_BIT_GID] = 1'b0;
		end else if (wr_cpu_status) begin
			cpu_status_nxt = i_wdata;
		end
	end

	always @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cpu_status_reg_r <= `FVI_RST_CPU_STATUS;
		end else begin
			cpu_status_reg_r <= cpu_status_nxt;
		end
	end

	// Flags set on events whatever the enables; set wins over a write clear
	always @* begin
		int_status_nxt = int_status_ctrl_reg_r;
		if (wr_int_status) begin
			int_status_nxt[6:0] = i_wdata[6:0];
		end
		if (ext_pin_edge) begin
			int_status_nxt[`FVI_BIT_EXT_FLAG] = 1'b1;
		end
		if (i_timer_overflow) begin
			int_status_nxt[`FVI_BIT_TMR_FLAG] = 1'b1;
		end
		if (tck_pin_edge) begin
			int_status_nxt[`FVI_BIT_TCK_FLAG] = 1'b1;
		end
		// The summary bit exists in the read path only
		int_status_nxt[`FVI_BIT_PERI_FLAG] = 1'b0;
	end

	always @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			int_status_ctrl_reg_r <= `FVI_RST_INT_STATUS;
		end else begin
			int_status_ctrl_reg_r <= int_status_nxt;
		end
	end

	always @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			timer_status_ctrl_reg_r <= `FVI_RST_TMR_STATUS;
		end else if (wr_tmr_status) begin
			timer_status_ctrl_reg_r <= i_wdata;
		end
	end

	always @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			peripheral_enable_regs_r <= {NPERI{1'b0}};
		end else if (wr_peri_en) begin
			peripheral_enable_regs_r <= i_wdata[NPERI-1:0];
		end
	end

	// Peripheral request flags: event set wins over software clear
	always @* begin
		peri_req_nxt = peripheral_request_regs_r;
		if (wr_peri_req) begin
			peri_req_nxt = i_wdata[NPERI-1:0];
		end
		peri_req_nxt = peri_req_nxt | i_peri_event;
	end

	always @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			peripheral_request_regs_r <= {NPERI{1'b0}};
		end else begin
			peripheral_request_regs_r <= peri_req_nxt;
		end
	end

	// Fixed priority: lowest pending index wins, one-hot grant
	always @* begin
		grant = 4'b0000;
		if (pend[0]) begin
			grant = 4'b0001;
		end else if (pend[1]) begin
			grant = 4'b0010;
		end else if (pend[2]) begin
			grant = 4'b0100;
		end else if (pend[3]) begin
			grant = 4'b1000;
		end
	end

	always @* begin
		case (grant)
			4'b0001: begin
				vector_sel = `FVI_VEC_EXT;
			end
			4'b0010: begin
				vector_sel = `FVI_VEC_TMR;
			end
			4'b0100: begin
				vector_sel = `FVI_VEC_TCK;
			end
			4'b1000: begin
				vector_sel = `FVI_VEC_PERI;
			end
			default: begin
				vector_sel = `FVI_VEC_PERI;
			end
		endcase
	end

	// Redirect sequencer: from each of the three states, take enters entry, return instruction enters return, else idle; other codes go idle
	always @* begin
		case (seq_state_r)
			SEQ_IDLE, SEQ_ENTRY, SEQ_RETURN: begin
				if (take) begin
					seq_state_nxt = SEQ_ENTRY;
				end else if (i_return_from_interrupt_instr) begin
					seq_state_nxt = SEQ_RETURN;
				end else begin
					seq_state_nxt = SEQ_IDLE;
				end
			end
			default: begin
				seq_state_nxt = SEQ_IDLE;
			end
		endcase
	end

	always @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			seq_state_r <= SEQ_IDLE;
		end else begin
			seq_state_r <= seq_state_nxt;
		end
	end

	// Strobes to the core follow the sequencer state
	always @* begin
		o_pc_load    = (seq_state_r == SEQ_ENTRY) | (seq_state_r == SEQ_RETURN);
		o_stack_push = (seq_state_r == SEQ_ENTRY);
		o_stack_pop  = (seq_state_r == SEQ_RETURN);
	end

	// Vector redirect: only the return PC is stacked
	always @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			o_pc_value   <= 16'h0000;
			o_stack_data <= 16'h0000;
		end else if (take) begin
			o_stack_data <= i_return_pc;
			o_pc_value   <= vector_sel;
		end else if (i_return_from_interrupt_instr) begin
			o_pc_value <= i_stack_top;
		end
	end

	always @* begin
		rdata_nxt = 8'h00;
		case (i_addr)
			`FVI_ADDR_CPU_STATUS: begin
				rdata_nxt = cpu_status_reg_r;
			end
			`FVI_ADDR_INT_STATUS: begin
				rdata_nxt = {peripheral_summary_flag,
					int_status_ctrl_reg_r[6:0]};
			end
			`FVI_ADDR_TMR_STATUS: begin
				rdata_nxt = timer_status_ctrl_reg_r;
			end
			`FVI_ADDR_PERI_REQ: begin
				rdata_nxt = peripheral_request_regs_r;
			end
			`FVI_ADDR_PERI_EN: begin
				rdata_nxt = peripheral_enable_regs_r;
			end
			`FVI_ADDR_PEND: begin
				rdata_nxt = {4'h0, pend};
			end
			default: begin
				rdata_nxt = 8'h00;
			end
		endcase
	end

	always @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= rdata_nxt;
		end else begin
			o_rdata <= 8'h00;
		end
	end
endmodule

/* test/fvi_unit_sva.sv */
// Protocol checker for the four vector interrupt unit
module fvi_unit_sva (
	input wire logic        i_clk_sys,
	input wire logic        i_rst_b,
	input wire logic        i_core_accept,
	input wire logic        i_return_from_interrupt_instr,
	input wire logic [15:0] i_return_pc,
	input wire logic [15:0] i_stack_top,
	input wire logic        o_int_request,
	input wire logic        o_pc_load,
	input wire logic [15:0] o_pc_value,
	input wire logic        o_stack_push,
	input wire logic [15:0] o_stack_data,
	input wire logic        o_stack_pop,
	input wire logic        o_wake,
	input wire logic        o_global_int_disable
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	wire take = o_int_request && i_core_accept;
	AST_TAKE: assert property (take |=> o_pc_load && o_stack_push && o_global_int_disable)
		else $error("taken interrupt did not vector");
	AST_BLOCK: assert property (o_global_int_disable |-> !o_int_request)
		else $error("request while disabled");
	AST_RET: assert property (i_return_from_interrupt_instr && !take |=>
		o_stack_pop && !o_global_int_disable && o_pc_value == $past(i_stack_top))
		else $error("return did not pop");
	AST_VEC: assert property (o_stack_push |->
		o_pc_value inside {16'h0008, 16'h0010, 16'h0018, 16'h0020})
		else $error("bad vector");
	AST_PUSH: assert property (o_stack_push |-> o_stack_data == $past(i_return_pc))
		else $error("pushed wrong address");
	AST_WAKE: assert property (take && !o_wake |=> o_pc_value == 16'h0010)
		else $error("waking source taken without wake");
	AST_ONCE: assert property (o_stack_push |-> !o_int_request ##1 !o_stack_push)
		else $error("second take before disable cleared");
	AST_LOAD: assert property (o_pc_load |-> o_stack_push ^ o_stack_pop)
		else $error("load without push or pop");
	cover property (take);
	cover property (o_stack_pop);
	cover property (o_wake && o_global_int_disable);
endmodule
bind fvi_unit fvi_unit_sva u_sva (.*);

/* test/fvi_core_model.sv */
// Core sequencer and hardware stack facing the interrupt unit
module fvi_core_model (
	input  wire logic        i_clk,
	input  wire logic        i_slow,
	input  wire logic        i_req,
	input  wire logic        i_push,
	input  wire logic [15:0] i_data,
	input  wire logic        i_pop,
	output logic             o_accept,
	output logic [15:0]      o_top
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] stk[$];
	logic        tick = 0;
	initial o_accept = 0;
	// Slow mode accepts only on every other cycle
	always @(posedge i_clk) begin
		tick <= !tick;
		o_accept <= i_req && (!i_slow || tick);
		if (i_push) stk.push_back(i_data);
		if (i_pop && stk.size() > 0) void'(stk.pop_back());
	end
	assign o_top = stk.size() > 0 ? stk[$] : 16'hffff;
endmodule

/* test/fvi_unit_tb.sv */
// Self-checking bench for the four vector interrupt unit
module fvi_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rst_b = 0, wr = 0, rd = 0, ext = 0, tck = 0, ovf = 0;
	logic        ret = 0, slow = 0, rdv = 0, req, acc, load, push, pop;
	logic [7:0]  addr = 0, wdata = 0, peri = 0, rdata;
	logic [15:0] rpc = 0, pcv, top, sdata;
	logic        wake, gid;
	logic [31:0] seed = 32'hfd24;
	logic [7:0]  qr[$];
	logic [15:0] qp[$];
	int          n_errors = 0, total_checks = 0, cyc = 0;
	fvi_unit u_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ext_interrupt_pin(ext),
		.i_timer_clock_interrupt_pin(tck), .i_timer_overflow(ovf), .i_peri_event(peri),
		.i_core_accept(acc), .i_return_from_interrupt_instr(ret), .i_return_pc(rpc),
		.i_stack_top(top), .o_int_request(req), .o_pc_load(load), .o_pc_value(pcv),
		.o_stack_push(push), .o_stack_data(sdata), .o_stack_pop(pop), .o_wake(wake),
		.o_global_int_disable(gid));
	fvi_core_model u_core (.i_clk(clk), .i_slow(slow), .i_req(req), .i_push(push),
		.i_data(sdata), .i_pop(pop), .o_accept(acc), .o_top(top));
	function automatic logic [15:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	task automatic wrt(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic rdx(input logic [7:0] a, input logic [7:0] e);
		qr.push_back(e);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
	endtask
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk) rdv <= rd;
	// Results are matched against the oldest note of their kind
	always @(negedge clk) begin
		if (rdv) cmp({8'h00, rdata}, {8'h00, qr.pop_front()});
		if (load) cmp(pcv, qp.pop_front());
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			stop_test();
		end
	end
	initial forever #4 clk = ~clk;
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		cmp({15'h0000, gid}, 16'h0001);
		cmp({15'h0000, wake}, 16'h0000);
		rdx(8'h00, 8'h10);
		rdx(8'h3c, 8'h00);
		wrt(8'h02, 8'hc0);
		wrt(8'h04, 8'h01);
		ext <= 1;
		tck <= 1;
		ovf <= 1;
		peri <= 8'h01;
		@(posedge clk);
		ovf <= 0;
		peri <= 8'h00;
		repeat (4) @(posedge clk);
		rdx(8'h01, 8'hf0);
		wrt(8'h01, 8'h00);
		wrt(8'h02, 8'h00);
		ext <= 0;
		tck <= 0;
		ovf <= 1;
		@(posedge clk);
		ovf <= 0;
		repeat (4) @(posedge clk);
		rdx(8'h01, 8'hf0);
		wrt(8'h01, 8'hf7);
		@(negedge clk);
		cmp({15'h0000, wake}, 16'h0001);
		cmp({15'h0000, req}, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			rpc <= xs();
			slow <= i[0];
			qp.push_back(16'(8 * (i + 1)));
			if (i == 0) wrt(8'h00, 8'h00);
			if (i == 3) wrt(8'h01, 8'h0f);
			for (int k = 0; k < 20 && !push; k++) @(negedge clk);
			if (i < 3) wrt(8'h01, 8'(8'h07 | (8'h70 & (8'h70 << (i + 1)))));
			else wrt(8'h03, 8'h00);
			qp.push_back(rpc);
			@(posedge clk);
			ret <= 1;
			@(posedge clk);
			ret <= 0;
		end
		wrt(8'h00, 8'h10);
		wrt(8'h01, 8'h00);
		rdx(8'h00, 8'h10);
		repeat (8) @(posedge clk);
		cmp(16'(qp.size() + qr.size()), 16'h0000);
		stop_test();
	end
endmodule
